// ===== verilog/acs_pkg.sv
// Constants, types and the function list of the conversion sequencer.
// Function
// R1 - Each continuous result overwrites the stored one.
// R2 - Interrupt after every continuous conversion, first included.
// R3 - First result after 5129 cycles, plus 40 waking.
// R4 - Start bit clears at first result, stays clear.
// R5 - Later continuous results every 256 cycles.
// R6 - Result: upper byte, three low bits 7:5.
// R7 - Clearing mode stops further continuous conversions.
// R8 - Interrupts only while converting; pending not withdrawn.
// R9 - Writing zero to start bit does nothing.
// R10 - Writing one starts or restarts a conversion.
// R11 - Single-shot gives one result, then stops.
// R12 - Reference code: off, 1.0 V, 2.0 V default.
// R13 - Pin buffer on while pin-drive bit set.
// R14 - Software keeps internal reference on for pin.
// R15 - Codes 0-7 pick inputs; others open all.
// R16 - Software writes reference high bit first.
// R17 - Conversion control layout, all fields reset zero.
// R18 - Reference control: bit 7 resets to one.
// R19 - Readable raw value spans 13 bits.
// R20 - Power down after 160 idle; 40 to wake.
// R21 - Upper byte read captures matching lower bits.
// R22 - Interrupt is one-cycle pulse with the store.
// R23 - Mode cleared: finish current, discard, go idle.
package acs_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_CONV_CTRL = 12'hf70;
  localparam logic [11:0] IDX_REF_CTRL  = 12'hf71;
  localparam logic [11:0] IDX_RES_UPPER = 12'hf72;
  localparam logic [11:0] IDX_RES_LOWER = 12'hf73;
  // Word select inside the four-register window.
  localparam logic [1:0]  SEL_CONV      = IDX_CONV_CTRL[1:0];
  localparam logic [1:0]  SEL_REF       = IDX_REF_CTRL[1:0];
  localparam logic [1:0]  SEL_UPPER     = IDX_RES_UPPER[1:0];
  localparam logic [1:0]  SEL_LOWER     = IDX_RES_LOWER[1:0];
  // Upper address bits that must match for a hit.
  localparam logic [27:0] WIN_TAG       = {18'h0, IDX_CONV_CTRL[11:2]};
  // Field positions.
  localparam int          BIT_GO        = 7;
  localparam int          BIT_REF_LO    = 6;
  localparam int          BIT_PIN       = 5;
  localparam int          BIT_MODE      = 4;
  localparam int          BIT_REF_HI    = 7;
  localparam int          CH_W          = 4;
  localparam int          NUM_INPUTS    = 8;
  // Values after reset.
  localparam logic [7:0]  CONV_CTRL_RST = 8'h00;
  localparam logic [7:0]  REF_CTRL_RST  = 8'h80;
  // Raw result layout.
  localparam int          RES_W         = 13;
  localparam int          UPPER_LSB     = 5;
  // Reference level codes.
  localparam logic [1:0]  REF_OFF       = 2'h0;
  localparam logic [1:0]  REF_1V0       = 2'h1;
  localparam logic [1:0]  REF_2V0       = 2'h2;
  // Cycle counts at the system clock.
  localparam int          CONV_CYCLES   = 5129;
  localparam int          WAKE_CYCLES   = 40;
  localparam int          REPEAT_CYCLES = 256;
  localparam int          IDLE_CYCLES   = 160;
  localparam int          CNT_W         = 13;
  localparam int          IDLE_W        = 8;
  // Bus response.
  localparam logic        HRESP_OKAY    = 1'b0;

  // Sequencer states.
  typedef enum logic [2:0] {
    ACS_IDLE   = 3'b000,
    ACS_WAKE   = 3'b001,
    ACS_FIRST  = 3'b010,
    ACS_REPEAT = 3'b011,
    ACS_DRAIN  = 3'b100
  } acs_state_t;

  // Register access from the bus port to the register file.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } acs_reg_req_t;
endpackage

// ===== verilog/acs_ahb_port.sv
// AHB-Lite slave front end that turns transfers into register strobes.
`timescale 1ns/1ps
module acs_ahb_port (
  // Clock and reset.
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave side.
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Register file side.
  output acs_pkg::acs_reg_req_t      req,
  input  wire logic [7:0]            rd_data
);
  import acs_pkg::*;

  logic       ph_write; // Data phase of a write is under way.
  logic       ph_read;  // Read waits one cycle to fetch fresh data.
  logic       ph_hit;   // The pending transfer hits the window.
  logic [1:0] ph_sel;   // Word select of the pending transfer.
  logic       take;     // An address phase is accepted.
  logic       hit;      // Address decodes to one of our words.

  // Anything but a whole-word transfer misses the window and reads as zero.
  assign take = hsel && hready && htrans[1];
  assign hit  = (haddr[31:4] == WIN_TAG) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);

  // Capture the address phase; the write and read flags last one cycle, hit and select hold until the next one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write <= 1'b0;
      ph_read  <= 1'b0;
      ph_hit   <= 1'b0;
      ph_sel   <= 2'h0;
    end else begin
      ph_write <= take && hwrite;
      ph_read  <= take && !hwrite;
      if (take) begin
        ph_hit <= hit;
        ph_sel <= haddr[3:2];
      end
    end
  end

  // The read wait state lets a read right after a write see the new value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ph_read) begin
      hrdata <= ph_hit ? {24'h0, rd_data} : 32'h0;
    end
  end

  // Writes finish with no wait; reads hold ready low for one cycle.
  assign hreadyout = !ph_read;
  assign hresp     = HRESP_OKAY;
  assign req.wr    = ph_write && ph_hit;
  assign req.rd    = ph_read && ph_hit;
  assign req.sel   = ph_sel;
  assign req.wdata = hwdata[7:0];
endmodule

// ===== verilog/acs_sequencer.sv
// Conversion sequencer top: registers, power and conversion timing.
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES
) (
  // Clock and reset.
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // AHB-Lite register bus.
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // Filter output, same clock domain.
  input  wire logic [acs_pkg::RES_W-1:0]   adc_sample,
  input  wire logic                        adc_overflow,
  // Analog front end controls.
  output logic [acs_pkg::NUM_INPUTS-1:0]   input_switch_en,
  output logic [1:0]                       ref_level_code,
  output logic                             ref_internal_on,
  output logic                             ref_pin_drive,
  output logic                             converter_power_on,
  output logic                             conversion_active,
  // Request to the interrupt controller.
  output logic                             conv_irq
);
  import acs_pkg::*;

  // Counter reload values, cut to the counter width on purpose.
  localparam logic [CNT_W-1:0]  CONV_LOAD   = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0]  WAKE_LOAD   = CNT_W'(WAKE_CYCLES - 1);
  localparam logic [CNT_W-1:0]  REPEAT_LOAD = CNT_W'(REPEAT_CYCLES - 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST   = IDLE_W'(IDLE_CYCLES - 1);

  acs_reg_req_t      req;          // Register strobes from the bus port.
  logic [7:0]        rd_data;      // Read mux into the bus port.
  logic [7:0]        conv_control; // Start, reference low, pin, mode, channel.
  logic [7:0]        ref_control;  // Reference high bit and spare bits.
  logic [7:0]        result_upper; // Upper eight result bits.
  logic [4:0]        result_low;   // Three result bits and two trim bits.
  logic              result_ovf;   // Filter overflow for this result.
  logic [7:0]        lower_live;   // Lower register image of the newest result.
  logic [7:0]        result_lower; // Lower byte latched by an upper read.
  acs_state_t        state;        // Sequencer state.
  acs_state_t        next_state;   // Sequencer state for the next cycle.
  logic [CNT_W-1:0]  cnt;          // Down counter of the running phase.
  logic [IDLE_W-1:0] idle_cnt;     // Consecutive idle cycles while powered.
  logic              powered;      // Converter core is powered up.
  logic              start;        // Software wrote one to the start bit.
  logic              cnt_done;     // Last cycle of the running phase.
  logic              store_stb;    // A result is written this edge.
  logic              first_done;   // The first conversion ends this edge.
  logic              conversion_go;   // Start bit.
  logic              repeat_mode_sel; // Continuous mode bit.
  logic [CH_W-1:0]   channel_select;  // Analog input code.

  // Bus port instance.
  acs_ahb_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .req       (req),
    .rd_data   (rd_data)
  );

  // Field views of the control registers.
  assign conversion_go   = conv_control[BIT_GO];
  assign repeat_mode_sel = conv_control[BIT_MODE];
  assign channel_select  = conv_control[CH_W-1:0];

  // A write of one to the start bit restarts whatever runs now.
  assign start = req.wr && (req.sel == SEL_CONV) && req.wdata[BIT_GO]; // see R10
  assign cnt_done = (cnt == '0);

  // A restart in the completing cycle discards that result.
  assign first_done = cnt_done && (state == ACS_FIRST) && !start;
  assign store_stb  = first_done
                   || (cnt_done && (state == ACS_REPEAT) && repeat_mode_sel && !start);

  // Next state of the sequencer.
  always_comb begin
    next_state = state;
    if (start) begin
      // Wake first if the core was powered down.
      next_state = powered ? ACS_FIRST : ACS_WAKE; // see R20
    end else begin
      unique case (state)
        ACS_IDLE: begin
          next_state = ACS_IDLE;
        end
        ACS_WAKE: begin
          if (cnt_done) begin
            next_state = ACS_FIRST; // see R3
          end
        end
        ACS_FIRST: begin
          // Single-shot stops after one result.
          if (cnt_done) begin
            next_state = repeat_mode_sel ? ACS_REPEAT : ACS_IDLE; // see R11
          end
        end
        ACS_REPEAT: begin
          // Clearing the mode lets the current conversion run out unstored.
          if (!repeat_mode_sel) begin
            next_state = cnt_done ? ACS_IDLE : ACS_DRAIN; // see R7
          end
        end
        ACS_DRAIN: begin
          if (cnt_done) begin
            next_state = ACS_IDLE; // see R23
          end
        end
        default: begin
          next_state = ACS_IDLE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ACS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase counter: wake, first conversion, then the repeat period.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= powered ? CONV_LOAD : WAKE_LOAD; // see R3
    end else if (state == ACS_WAKE) begin
      cnt <= cnt_done ? CONV_LOAD : cnt - 1'b1; // see R3
    end else if ((state == ACS_FIRST) || (state == ACS_REPEAT)) begin
      cnt <= cnt_done ? REPEAT_LOAD : cnt - 1'b1; // see R5
    end else if ((state == ACS_DRAIN) && !cnt_done) begin
      cnt <= cnt - 1'b1;
    end
  end

  // Idle counter; the core sleeps after enough consecutive idle cycles.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= '0;
    end else if ((state != ACS_IDLE) || start || !powered) begin
      idle_cnt <= '0;
    end else if (idle_cnt != IDLE_LAST) begin
      idle_cnt <= idle_cnt + 1'b1; // see R20
    end
  end

  // Power flag: up after the wake phase, down after the idle run.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powered <= 1'b0;
    end else if ((state == ACS_WAKE) && cnt_done && !start) begin
      powered <= 1'b1; // see R20
    end else if ((state == ACS_IDLE) && !start && (idle_cnt == IDLE_LAST)) begin
      powered <= 1'b0; // see R20
    end
  end

  // Conversion control: start only sets, hardware clears; set wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_control <= CONV_CTRL_RST; // see R17
    end else begin
      if (req.wr && (req.sel == SEL_CONV)) begin
        conv_control[BIT_GO-1:0] <= req.wdata[BIT_GO-1:0]; // see R17
      end
      if (start) begin
        conv_control[BIT_GO] <= 1'b1; // see R10
      end else if (first_done) begin
        // Zero writes never land here; only completion clears it.
        conv_control[BIT_GO] <= 1'b0; // see R4 R9
      end
    end
  end

  // Reference control; spare bits are kept as written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_control <= REF_CTRL_RST; // see R18
    end else if (req.wr && (req.sel == SEL_REF)) begin
      ref_control <= req.wdata;
    end
  end

  // Result store; every new result replaces the last one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_upper <= 8'h00;
      result_low   <= 5'h00;
      result_ovf   <= 1'b0;
    end else if (store_stb) begin
      result_upper <= adc_sample[RES_W-1:UPPER_LSB]; // see R1 R6 R19
      result_low   <= adc_sample[UPPER_LSB-1:0];     // see R6 R19
      result_ovf   <= adc_overflow;
    end
  end

  // Lower image: three result bits, two trim bits, overflow at bit 0.
  assign lower_live = {result_low, 2'h0, result_ovf}; // see R6

  // Reading the upper byte freezes the lower byte to the same result.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_lower <= 8'h00;
    end else if (req.rd && (req.sel == SEL_UPPER)) begin
      result_lower <= lower_live; // see R21
    end
  end

  // Read mux; the bus port registers the value.
  always_comb begin
    unique case (req.sel)
      SEL_CONV:  rd_data = conv_control;
      SEL_REF:   rd_data = ref_control;
      SEL_UPPER: rd_data = result_upper;
      SEL_LOWER: rd_data = result_lower;
    endcase
  end

  // Interrupt pulse in the first cycle the new result is readable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= store_stb; // see R2 R8 R22
    end
  end

  // Input switches: one per input, all open for reserved codes.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_sw
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          input_switch_en[gi] <= 1'b0;
        end else begin
          input_switch_en[gi] <= (channel_select == CH_W'(gi)); // see R15
        end
      end
    end
  endgenerate

  // Reference controls straight from register bits.
  // Software must keep the reference on when it drives the pin.
  assign ref_level_code     = {ref_control[BIT_REF_HI], conv_control[BIT_REF_LO]}; // see R12
  assign ref_internal_on    = (ref_level_code != REF_OFF); // see R12
  assign ref_pin_drive      = conv_control[BIT_PIN]; // see R13
  assign converter_power_on = powered;
  assign conversion_active  = (state != ACS_IDLE);

  // Cycles since the last start, for checking the first-result latency.
  logic [CNT_W-1:0] age;
  logic             woke;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age  <= '0;
      woke <= 1'b0;
    end else if (start) begin
      age  <= '0;
      woke <= !powered;
    end else if (age != '1) begin
      age <= age + 1'b1;
    end
  end

  first_latency_a: assert property ( // see R3
    @(posedge hclk) disable iff (!hresetn)
    first_done |-> (age == (woke ? CNT_W'(CONV_CYCLES + WAKE_CYCLES - 1) : CONV_LOAD)))
    else $error("first result at wrong cycle");

  repeat_period_a: assert property ( // see R5
    @(posedge hclk) disable iff (!hresetn)
    (store_stb && (state == ACS_REPEAT)) |-> $past(store_stb, 256))
    else $error("repeat result not 256 cycles after previous");

  irq_with_store_a: assert property ( // see R22
    @(posedge hclk) disable iff (!hresetn)
    store_stb |=> conv_irq && (result_upper == $past(adc_sample[RES_W-1:UPPER_LSB])))
    else $error("interrupt not paired with new result");

  irq_only_store_a: assert property ( // see R8
    @(posedge hclk) disable iff (!hresetn)
    conv_irq |-> $past(state != ACS_IDLE) && $past(state != ACS_DRAIN))
    else $error("interrupt while not converting");

  go_clears_a: assert property ( // see R4
    @(posedge hclk) disable iff (!hresetn)
    first_done |=> !conversion_go ##1 (!conversion_go || $past(start)))
    else $error("start bit not cleared at first result");

  go_zero_write_a: assert property ( // see R9
    @(posedge hclk) disable iff (!hresetn)
    (conversion_go && !first_done && req.wr && (req.sel == SEL_CONV)) |=> conversion_go)
    else $error("zero write cleared start bit");

  switch_open_a: assert property ( // see R15
    @(posedge hclk) disable iff (!hresetn)
    channel_select[CH_W-1] |=> (input_switch_en == '0))
    else $error("switch closed for reserved code");

  powerdown_a: assert property ( // see R20
    @(posedge hclk) disable iff (!hresetn)
    $fell(powered) |-> $past(state == ACS_IDLE, 1) && $past(state == ACS_IDLE, 160))
    else $error("power down without 160 idle cycles");

  drain_quiet_a: assert property ( // see R23
    @(posedge hclk) disable iff (!hresetn)
    (state == ACS_DRAIN) |-> !store_stb ##1 !conv_irq)
    else $error("drained conversion stored a result");

  shadow_pair_a: assert property ( // see R21
    @(posedge hclk) disable iff (!hresetn)
    (req.rd && (req.sel == SEL_UPPER)) |=> (result_lower == $past(lower_live)))
    else $error("lower byte not latched by upper read");

  go_sets_a: assert property ( // see R10
    @(posedge hclk) disable iff (!hresetn)
    start |=> conversion_go && (state != ACS_IDLE))
    else $error("start did not begin a conversion");

  single_stop_a: assert property ( // see R11
    @(posedge hclk) disable iff (!hresetn)
    (first_done && !repeat_mode_sel) |=> (state == ACS_IDLE))
    else $error("single shot did not stop");
endmodule

// ===== sim/acs_filter_model.sv
// Behavioural model of the digital filter that feeds the sequencer.
`timescale 1ns/1ps
module acs_filter_model (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Sequencer side.
  input  wire logic        conv_irq,
  output logic [12:0]      adc_sample,
  output logic             adc_overflow,
  // Expected register contents for the bench.
  output logic [7:0]       exp_upper,
  output logic [7:0]       exp_lower,
  output int               irq_count
);
  // Step chosen odd so every bit of the sample toggles over time.
  localparam logic [12:0] STEP = 13'h0a3;
  logic [12:0] held;  // Sample that stood before the store edge.

  // Overflow follows a sample bit so the flag changes too.
  assign adc_overflow = adc_sample[3];
  assign held         = adc_sample - STEP;

  // The sample moves every cycle; a stale store would be caught.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_sample <= 13'h0123;
      exp_upper  <= 8'h00;
      exp_lower  <= 8'h00;
      irq_count  <= 0;
    end else begin
      adc_sample <= adc_sample + STEP;
      // The pulse follows the store edge, so the stored value is held.
      if (conv_irq) begin
        exp_upper <= held[12:5];
        exp_lower <= {held[4:0], 2'b00, held[3]};
        irq_count <= irq_count + 1;
      end
    end
  end
endmodule

// ===== sim/tb.sv
// Self-checking testbench for the conversion sequencer.
`timescale 1ns/1ps
module tb;
  import acs_pkg::*;
  // Shortened conversion keeps the run brief; wake and repeat stay real.
  localparam int CONV = 300;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ovf;
  logic        conv_irq, ref_internal_on, ref_pin_drive, pwr, active;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, ref_level_code;
  logic [2:0]  hsize;
  logic [12:0] sample;
  logic [7:0]  sw_en, exp_upper, exp_lower;
  int          irq_count;
  int          miscompares = 0;
  int          n_compared  = 0;

  acs_sequencer #(.CONV_CYCLES(CONV)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .adc_sample(sample),
    .adc_overflow(ovf), .input_switch_en(sw_en), .ref_level_code(ref_level_code),
    .ref_internal_on(ref_internal_on), .ref_pin_drive(ref_pin_drive),
    .converter_power_on(pwr), .conversion_active(active), .conv_irq(conv_irq));

  acs_filter_model u_filter (
    .hclk(hclk), .hresetn(hresetn), .conv_irq(conv_irq), .adc_sample(sample),
    .adc_overflow(ovf), .exp_upper(exp_upper), .exp_lower(exp_lower),
    .irq_count(irq_count));

  // Clock of 100 ns period.
  always #50 hclk = ~hclk;

  // Compares and counts; case inequality so an unknown never matches a known value.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single word transfer; ready and data are looked at mid-cycle, where stable.
  task bus(input logic w, input logic [11:0] idx, input logic [7:0] d,
           output logic [7:0] q);
    logic ok;
    hsel   <= 1'b1;
    haddr  <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    do begin
      @(negedge hclk) ok = hreadyout;
      @(posedge hclk);
    end while (ok !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do begin
      @(negedge hclk) ok = hreadyout;
      q = hrdata[7:0];
      @(posedge hclk);
    end while (ok !== 1'b1);
  endtask

  task wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task rd(input logic [11:0] idx, output logic [7:0] q);
    bus(1'b0, idx, 8'h00, q);
  endtask

  // Counts edges until the interrupt pulse is sampled; bounded.
  task wait_irq(output int n);
    logic v;
    n = 0;
    do begin
      @(negedge hclk) v = conv_irq;
      @(posedge hclk);
      n++;
    end while (v !== 1'b1 && n < 3000);
  endtask

  // Reset values, an unmapped read and the default reference.
  task t_reset;
    logic [7:0] q;
    rd(IDX_CONV_CTRL, q);
    chk(q, CONV_CTRL_RST);
    rd(IDX_REF_CTRL, q);
    chk(q, REF_CTRL_RST);
    rd(12'hf74, q);
    chk(q, 8'h00);
    chk(hresp, HRESP_OKAY);
    chk(ref_level_code, REF_2V0);
  endtask

  // Every channel code, reserved ones open all switches.
  task t_channels;
    for (int i = 0; i < 16; i++) begin
      wr(IDX_CONV_CTRL, 8'(i));
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      chk(sw_en, (i < 8) ? (8'h01 << i) : 8'h00);
      @(posedge hclk);
    end
  endtask

  // Single shot from power-down with the pin buffer and 1.0 V level.
  task t_single;
    logic [7:0] q;
    int         n;
    wr(IDX_REF_CTRL, 8'h00);
    wr(IDX_CONV_CTRL, 8'he5);
    wait_irq(n);
    chk(n, CONV + WAKE_CYCLES + 1);
    chk(pwr, 1'b1);
    chk({ref_level_code, ref_internal_on, ref_pin_drive}, {REF_1V0, 2'b11});
    chk(sw_en, 8'h20);
    rd(IDX_RES_UPPER, q);
    chk(q, exp_upper);
    rd(IDX_RES_LOWER, q);
    chk(q, exp_lower);
    rd(IDX_CONV_CTRL, q);
    chk(q, 8'h65);
  endtask

  // A zero write is ignored, a second start restarts from scratch.
  task t_restart;
    logic [7:0] q;
    int         n, c;
    c = irq_count;
    wr(IDX_CONV_CTRL, 8'h83);
    repeat (50) @(posedge hclk);
    wr(IDX_CONV_CTRL, 8'h03);
    rd(IDX_CONV_CTRL, q);
    chk(q, 8'h83);
    chk({ref_level_code, ref_internal_on}, {REF_OFF, 1'b0});
    repeat (50) @(posedge hclk);
    wr(IDX_CONV_CTRL, 8'h83);
    wait_irq(n);
    chk(n, CONV + 1);
    repeat (600) @(posedge hclk);
    chk(irq_count, c + 1);
  endtask

  // Continuous run: timing, start bit, latching, overwrite and stop.
  task t_repeat_mode_sel;
    logic [7:0] q, lo;
    int         n, c;
    chk(pwr, 1'b0);
    wr(IDX_REF_CTRL, 8'h80);
    wr(IDX_CONV_CTRL, 8'h92);
    wait_irq(n);
    chk(n, CONV + WAKE_CYCLES + 1);
    wait_irq(n);
    chk(n, REPEAT_CYCLES);
    rd(IDX_RES_UPPER, q);
    chk(q, exp_upper);
    lo = exp_lower;
    wait_irq(n);
    rd(IDX_RES_LOWER, q);
    chk(q, lo);
    rd(IDX_RES_UPPER, q);
    chk(q, exp_upper);
    rd(IDX_CONV_CTRL, q);
    chk(q, 8'h12);
    c = irq_count;
    wr(IDX_CONV_CTRL, 8'h02);
    repeat (600) @(posedge hclk);
    chk(irq_count, c);
    chk(active, 1'b0);
  endtask

  // Verdict and end of run.
  task wrap_up;
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence: reset for six cycles, then each scenario.
  initial begin
    hclk    = 1'b0;
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_single;
    t_restart;
    t_channels;
    t_repeat_mode_sel;
    wrap_up;
  end

  // Watchdog well beyond the few thousand cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    wrap_up;
  end
endmodule
